/* core/kpd_top.v */
/*
 Key wake module: pin edge/level detector with AXI4-Lite register slave.
 Assumes one 100 MHz clock, async active-low reset, asynchronous key pins.
*/
// Function
// - Detected press on an enabled pin sets its pressed-pin record bit.
// - Record cleared only by reset or writing 1 to record-clear command.
// - Record is read-only to software; resets to zero.
// - Eight key pins, each with its own enable; disabled pins ignored.
// - One mode control selects edge-only or edge-and-level detection.
// - Per-pin polarity picks falling/low or rising/high as asserted.
// - Falling edge is 1 then 0 on consecutive clock samples.
// - Rising edge is 0 then 1 on consecutive clock samples.
// - New edge only after all enabled inputs return deasserted.
// - Edge-only mode: valid edge sets flag; acknowledge write clears it.
// - Interrupt request while flag set and interrupt enable is 1.
// - Edge-and-level mode: edge or asserted level sets the flag.
// - Edge-and-level mode: acknowledge clears flag only with inputs deasserted.
// - Detections can wake the processor from stop or wait.
// - Polarity bit 0 is falling/low, 1 is rising/high.
// - Mode bit 0 detects edges only, 1 edges and levels.
// - Read select 0 returns live source pins, 1 the latched record.
// - Record-clear command acts on 1 and always reads 0.
`timescale 1ns/100ps
`include "kpd_consts.vh"

module kpd_top (
   input  wire                    sys_clk,
   input  wire                    rst_n,
   input  wire [`KPD_NPINS-1:0]   key_input_pin,
   input  wire [`KPD_ADDR_W-1:0]  s_axi_awaddr,
   input  wire [2:0]              s_axi_awprot,
   input  wire                    s_axi_awvalid,
   output wire                    s_axi_awready,
   input  wire [`KPD_DATA_W-1:0]  s_axi_wdata,
   input  wire [3:0]              s_axi_wstrb,
   input  wire                    s_axi_wvalid,
   output wire                    s_axi_wready,
   output wire [1:0]              s_axi_bresp,
   output wire                    s_axi_bvalid,
   input  wire                    s_axi_bready,
   input  wire [`KPD_ADDR_W-1:0]  s_axi_araddr,
   input  wire [2:0]              s_axi_arprot,
   input  wire                    s_axi_arvalid,
   output wire                    s_axi_arready,
   output wire [`KPD_DATA_W-1:0]  s_axi_rdata,
   output wire [1:0]              s_axi_rresp,
   output wire                    s_axi_rvalid,
   input  wire                    s_axi_rready,
   output wire                    key_irq,
   output wire                    key_wake_req
);

   localparam N = `KPD_NPINS;

   // Maps a byte address onto a register select code
   function [2:0] reg_sel;
      input [`KPD_ADDR_W-1:0] addr;
      begin
         case (addr)
            `KPD_OFS_PIN_EN:   reg_sel = `KPD_SEL_PIN_EN;
            `KPD_OFS_POLARITY: reg_sel = `KPD_SEL_POLARITY;
            `KPD_OFS_CTRL:     reg_sel = `KPD_SEL_CTRL;
            `KPD_OFS_RECORD:   reg_sel = `KPD_SEL_RECORD;
            default:           reg_sel = `KPD_SEL_NONE;
         endcase
      end
   endfunction

   // Software-visible state
   reg  [N-1:0]              pin_enable_bits_reg;
   reg  [N-1:0]              polarity_select_bits_reg;
   reg                       detect_mode_sel_reg;
   reg                       irq_enable_reg;
   reg                       latched_read_select_reg;
   reg                       key_event_flag_reg;
   reg  [N-1:0]              pressed_pin_record_reg;

   // Detection state
   reg  [N-1:0]              sample_prev_reg;
   reg                       armed_reg;
   reg                       key_irq_reg;
   reg                       key_wake_reg;

   // Bus slave state
   reg                       awready_reg;
   reg                       wready_reg;
   reg                       aw_got_reg;
   reg                       w_got_reg;
   reg  [`KPD_ADDR_W-1:0]    wr_addr_reg;
   reg  [`KPD_DATA_W-1:0]    wr_data_reg;
   reg                       wr_strb0_reg;
   reg                       bvalid_reg;
   reg  [1:0]                bresp_reg;
   reg                       arready_reg;
   reg                       rvalid_reg;
   reg  [1:0]                rresp_reg;
   reg  [`KPD_DATA_W-1:0]    rdata_reg;

   wire [N-1:0]              key_sync;
   wire [N-1:0]              asrt_now;
   wire [N-1:0]              asrt_prev;
   wire [N-1:0]              edge_hit;
   wire [N-1:0]              level_hit;
   wire [N-1:0]              press_hit;
   wire                      any_asserted;
   wire                      edge_any;
   wire                      flag_set;
   wire                      wr_commit;
   wire [2:0]                wr_sel;
   wire [2:0]                rd_sel;
   wire                      ctrl_wr;
   wire                      ack_wr;
   wire                      rec_clr_wr;
   wire                      ack_clears;
   wire                      irq_en_eff;
   reg                       flag_next;
   reg  [N-1:0]              record_next;
   reg                       armed_next;
   reg  [`KPD_DATA_W-1:0]    rd_word;

   kpd_sync u_sync (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .pin_async (key_input_pin),
      .pin_sync  (key_sync)
   );

   // Per-pin detection
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_det
         // Asserted level is the polarity bit's value
         assign asrt_now[i]  = ~(key_sync[i] ^ polarity_select_bits_reg[i]);
         assign asrt_prev[i] = ~(sample_prev_reg[i] ^ polarity_select_bits_reg[i]);
         // Deasserted then asserted on two consecutive samples
         assign edge_hit[i]  = pin_enable_bits_reg[i] & asrt_now[i] & ~asrt_prev[i]
                               & armed_reg;
         assign level_hit[i] = pin_enable_bits_reg[i] & asrt_now[i]
                               & detect_mode_sel_reg;
         assign press_hit[i] = edge_hit[i] | level_hit[i];
      end
   endgenerate

   assign any_asserted = |(asrt_now & pin_enable_bits_reg);
   assign edge_any     = |edge_hit;
   assign flag_set     = |press_hit;

   // Write path decode
   // Only byte lane 0 carries fields; lanes 3:1 are ignored
   assign wr_commit  = aw_got_reg & w_got_reg & ~bvalid_reg;
   assign wr_sel     = reg_sel(wr_addr_reg);
   assign rd_sel     = reg_sel(s_axi_araddr);
   assign ctrl_wr    = wr_commit & wr_strb0_reg & (wr_sel == `KPD_SEL_CTRL);
   assign ack_wr     = ctrl_wr & wr_data_reg[`KPD_CTRL_ACK];
   assign rec_clr_wr = ctrl_wr & wr_data_reg[`KPD_CTRL_REC_CLR];
   // Level mode refuses the acknowledge while any enabled pin is asserted
   assign ack_clears = ack_wr & ~(detect_mode_sel_reg & any_asserted);
   // Irq enable as it stands once this cycle's write lands
   assign irq_en_eff = ctrl_wr ? wr_data_reg[`KPD_CTRL_IRQ_EN] : irq_enable_reg;

   always @* begin
      flag_next = key_event_flag_reg;
      if (ack_clears) begin
         flag_next = 1'b0;
      end
      // A detection in the acknowledge cycle is kept
      if (flag_set) begin
         flag_next = 1'b1;
      end
   end

   always @* begin
      // Clear first, then OR in this cycle's presses: set wins
      record_next = pressed_pin_record_reg;
      if (rec_clr_wr) begin
         record_next = {N{1'b0}};
      end
      record_next = record_next | press_hit;
   end

   // Edges re-arm only once every enabled input is back at rest
   always @* begin
      armed_next = armed_reg;
      if (edge_any) begin
         armed_next = 1'b0;
      end else if (!any_asserted) begin
         armed_next = 1'b1;
      end
   end

   // Detection and control registers
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_enable_bits_reg      <= `KPD_RST_PIN_EN;
         polarity_select_bits_reg <= `KPD_RST_POLARITY;
         detect_mode_sel_reg      <= 1'b0;
         irq_enable_reg           <= 1'b0;
         latched_read_select_reg  <= 1'b0;
         key_event_flag_reg       <= 1'b0;
         pressed_pin_record_reg   <= `KPD_RST_RECORD;
         // Pins start disabled, so a zero first sample raises no edge
         sample_prev_reg          <= {N{1'b0}};
         // Disarmed until one all-idle cycle has been seen
         armed_reg                <= 1'b0;
         key_irq_reg              <= 1'b0;
         key_wake_reg             <= 1'b0;
      end else begin
         sample_prev_reg        <= key_sync;
         armed_reg              <= armed_next;
         key_event_flag_reg     <= flag_next;
         pressed_pin_record_reg <= record_next;
         if (wr_commit && wr_strb0_reg) begin
            case (wr_sel)
               `KPD_SEL_PIN_EN: begin
                  pin_enable_bits_reg <= wr_data_reg[N-1:0];
               end
               `KPD_SEL_POLARITY: begin
                  polarity_select_bits_reg <= wr_data_reg[N-1:0];
               end
               `KPD_SEL_CTRL: begin
                  detect_mode_sel_reg     <= wr_data_reg[`KPD_CTRL_MODE];
                  irq_enable_reg          <= wr_data_reg[`KPD_CTRL_IRQ_EN];
                  latched_read_select_reg <= wr_data_reg[`KPD_CTRL_LATCH_SEL];
               end
               default: begin
                  // Record and unmapped offsets ignore writes
               end
            endcase
         end
         key_irq_reg  <= flag_next & irq_en_eff;
         // Wake follows the request, including the raw detection cycle
         key_wake_reg <= (flag_next | flag_set) & irq_en_eff;
      end
   end

   // Read data mux
   always @* begin
      rd_word = {`KPD_DATA_W{1'b0}};
      case (rd_sel)
         `KPD_SEL_PIN_EN: begin
            rd_word[N-1:0] = pin_enable_bits_reg;
         end
         `KPD_SEL_POLARITY: begin
            rd_word[N-1:0] = polarity_select_bits_reg;
         end
         `KPD_SEL_CTRL: begin
            // Commands and upper bits read as zero
            rd_word[`KPD_CTRL_MODE]      = detect_mode_sel_reg;
            rd_word[`KPD_CTRL_IRQ_EN]    = irq_enable_reg;
            rd_word[`KPD_CTRL_FLAG]      = key_event_flag_reg;
            rd_word[`KPD_CTRL_LATCH_SEL] = latched_read_select_reg;
         end
         `KPD_SEL_RECORD: begin
            // Live view shows enabled pins currently asserted
            rd_word[N-1:0] = latched_read_select_reg ? pressed_pin_record_reg
                                                     : (asrt_now & pin_enable_bits_reg);
         end
         default: begin
            rd_word = {`KPD_DATA_W{1'b0}};
         end
      endcase
   end

   // AXI4-Lite write channel: address and data in either order
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         awready_reg  <= 1'b1;
         wready_reg   <= 1'b1;
         aw_got_reg   <= 1'b0;
         w_got_reg    <= 1'b0;
         wr_addr_reg  <= {`KPD_ADDR_W{1'b0}};
         wr_data_reg  <= {`KPD_DATA_W{1'b0}};
         wr_strb0_reg <= 1'b0;
         bvalid_reg   <= 1'b0;
         bresp_reg    <= `KPD_RESP_OKAY;
      end else begin
         if (awready_reg && s_axi_awvalid) begin
            awready_reg <= 1'b0;
            aw_got_reg  <= 1'b1;
            wr_addr_reg <= s_axi_awaddr;
         end
         if (wready_reg && s_axi_wvalid) begin
            wready_reg   <= 1'b0;
            w_got_reg    <= 1'b1;
            wr_data_reg  <= s_axi_wdata;
            wr_strb0_reg <= s_axi_wstrb[0];
         end
         // Whichever half came first waits in its _got flag
         if (wr_commit) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg  <= (wr_sel == `KPD_SEL_NONE) ? `KPD_RESP_SLVERR : `KPD_RESP_OKAY;
         end
         // Ready returns only after the response, one write at a time
         if (bvalid_reg && s_axi_bready) begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   // AXI4-Lite read channel
   // Data taken at the address handshake: one edge of latency, no waits
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= `KPD_RESP_OKAY;
         rdata_reg   <= {`KPD_DATA_W{1'b0}};
      end else begin
         if (arready_reg && s_axi_arvalid) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_word;
            rresp_reg   <= (rd_sel == `KPD_SEL_NONE) ? `KPD_RESP_SLVERR : `KPD_RESP_OKAY;
         end
         if (rvalid_reg && s_axi_rready) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // Every output comes straight from a flop
   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;
   assign key_irq       = key_irq_reg;
   assign key_wake_req  = key_wake_reg;

endmodule

/* core/kpd_consts.vh */
/*
 Constants of the key wake module: register offsets, field positions,
 reset values and widths. Assumes inclusion by the design and bench files.
*/
`ifndef KPD_CONSTS_VH
`define KPD_CONSTS_VH

// Pins and bus widths
`define KPD_NPINS          8
`define KPD_ADDR_W         12
`define KPD_DATA_W         32

// Register byte offsets
`define KPD_OFS_PIN_EN     12'h000
`define KPD_OFS_POLARITY   12'h004
`define KPD_OFS_CTRL       12'h008
`define KPD_OFS_RECORD     12'h00c

// Register select codes
`define KPD_SEL_PIN_EN     3'h0
`define KPD_SEL_POLARITY   3'h1
`define KPD_SEL_CTRL       3'h2
`define KPD_SEL_RECORD     3'h3
`define KPD_SEL_NONE       3'h4

// Control register fields
`define KPD_CTRL_MODE      0
`define KPD_CTRL_IRQ_EN    1
`define KPD_CTRL_ACK       2
`define KPD_CTRL_FLAG      3
`define KPD_CTRL_LATCH_SEL 4
`define KPD_CTRL_REC_CLR   5

// Reset values
`define KPD_RST_PIN_EN     8'h00
`define KPD_RST_POLARITY   8'h00
`define KPD_RST_RECORD     8'h00

// Bus responses
`define KPD_RESP_OKAY      2'b00
`define KPD_RESP_SLVERR    2'b10

`endif

/* core/kpd_sync.v */
/*
 Two-stage synchroniser for the key input pins, one stage pair per pin.
 Assumes pins are asynchronous to sys_clk; only the second stage is used.
*/
`timescale 1ns/100ps
`include "kpd_consts.vh"

module kpd_sync (
   input  wire                    sys_clk,
   input  wire                    rst_n,
   input  wire [`KPD_NPINS-1:0]   pin_async,
   output wire [`KPD_NPINS-1:0]   pin_sync
);

   reg [`KPD_NPINS-1:0] meta_reg;
   reg [`KPD_NPINS-1:0] sync_reg;

   genvar i;
   generate
      for (i = 0; i < `KPD_NPINS; i = i + 1) begin : g_pin
         // First stage feeds the second stage only
         always @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_reg[i] <= 1'b0;
               sync_reg[i] <= 1'b0;
            end else begin
               meta_reg[i] <= pin_async[i];
               sync_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

   assign pin_sync = sync_reg;

endmodule

/* tb/kpd_monitor.sv */
/* Port checker for the key wake module.
 Bound to kpd_top; sees its ports only. */
`timescale 1ns/100ps
`include "kpd_consts.vh"
module kpd_monitor (
   input wire        sys_clk,
   input wire        rst_n,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        key_irq,
   input wire        key_wake_req
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence aw_w_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
      else $error("write answer not on time");
   a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read answer not on time");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_unmapped_error: assert property (ar_taken and s_axi_araddr > 12'h00c |=>
      s_axi_rresp == `KPD_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_record_upper_zero: assert property (ar_taken and s_axi_araddr == `KPD_OFS_RECORD
      |=> s_axi_rdata[31:8] == 24'h0)
      else $error("record upper bits set");
   a_commands_read_zero: assert property (ar_taken and s_axi_araddr == `KPD_OFS_CTRL
      |=> !s_axi_rdata[5] && !s_axi_rdata[2])
      else $error("command bit read back as one");
   a_irq_fall_write: assert property ($fell(key_irq) |->
      s_axi_bvalid || $past(s_axi_bvalid))
      else $error("request dropped without a write");
   a_wake_with_irq: assert property (key_irq |-> key_wake_req)
      else $error("wake missing while request up");
endmodule
bind kpd_top kpd_monitor mon_u (.sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .key_irq, .key_wake_req);

/* tb/kpd_keys.sv */
/* Key switch model on the far side of the key wake module.
 Assumes press and polarity come from the bench. */
`timescale 1ns/100ps
module kpd_keys (
   input  wire [7:0] press,
   input  wire [7:0] pol,
   output wire [7:0] key_input_pin
);
   // Released keys rest deasserted; skewed off the clock edge
   assign #3 key_input_pin = ~(pol ^ press);
endmodule

/* tb/kpd_top_bench.sv */
/* Self-checking bench for the key wake module.
 Drives AXI4-Lite and the key pins through kpd_keys. */
`timescale 1ns/100ps
`include "kpd_consts.vh"
module kpd_top_bench;
   logic        sys_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, rd, rng;
   logic [7:0]  press, pol;
   logic [1:0]  rs;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire         s_axi_rvalid, key_irq, key_wake_req;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [31:0]  s_axi_rdata;
   wire [7:0]   key_input_pin;
   int          err_count, n_checks, i;
   kpd_keys keys_u (.press, .pol, .key_input_pin);
   kpd_top dut_u (.sys_clk, .rst_n, .key_input_pin, .s_axi_awaddr, .s_axi_awprot(3'h0),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .key_irq, .key_wake_req);
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // Extra edge at the end so back-to-back calls never drive twice at once
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rdr(input logic [11:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      rdr(a);
      chk(rd, e);
   endtask
   // Mask, polarity, enable, ack, clear record, unmask
   task automatic setup(input logic [7:0] pe, input logic [7:0] pl, input logic m);
      wr(`KPD_OFS_CTRL, {31'h0, m});
      pol <= pl;
      wr(`KPD_OFS_POLARITY, {24'h0, pl});
      wr(`KPD_OFS_PIN_EN, {24'h0, pe});
      wr(`KPD_OFS_CTRL, {31'h1a, m});
      wr(`KPD_OFS_CTRL, {31'h09, m});
   endtask
   task automatic look(input logic f, input logic [7:0] r, input logic m);
      rc(`KPD_OFS_CTRL, {28'h1, f, 2'b01, m});
      rc(`KPD_OFS_RECORD, {24'h0, r});
      chk({31'h0, key_irq}, {31'h0, f});
   endtask
   task automatic settle();
      repeat (6) @(posedge sys_clk);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      #300000;
      err_count++;
      results();
   end
   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, press, pol} = 0;
      rng = 32'd30979;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      for (i = 0; i < 4; i++) rc(12'(4 * i), 32'h0);
      rdr(12'h010);
      chk({30'h0, rs}, {30'h0, `KPD_RESP_SLVERR});
      wr(`KPD_OFS_RECORD, 32'hff);
      chk({30'h0, rs}, {30'h0, `KPD_RESP_OKAY});
      rc(`KPD_OFS_RECORD, 32'h0);
      wr(12'h010, 32'h1);
      chk({30'h0, rs}, {30'h0, `KPD_RESP_SLVERR});
      $display("test reset and map done");
      setup(8'h0c, 8'h00, 1'b0);
      press <= 8'h04;
      settle();
      look(1'b1, 8'h04, 1'b0);
      chk({31'h0, key_wake_req}, 32'h1);
      press <= 8'h24;
      wr(`KPD_OFS_CTRL, 32'h16);
      look(1'b0, 8'h04, 1'b0);
      press <= 8'h0c;
      settle();
      look(1'b0, 8'h04, 1'b0);
      press <= 8'h00;
      settle();
      press <= 8'h08;
      settle();
      look(1'b1, 8'h0c, 1'b0);
      wr(`KPD_OFS_CTRL, 32'h02);
      rc(`KPD_OFS_RECORD, 32'h08);
      press <= 8'h00;
      wr(`KPD_OFS_CTRL, 32'h36);
      rc(`KPD_OFS_CTRL, 32'h12);
      rc(`KPD_OFS_RECORD, 32'h0);
      $display("test edge mode done");
      setup(8'h01, 8'h01, 1'b1);
      press <= 8'h01;
      settle();
      wr(`KPD_OFS_CTRL, 32'h17);
      look(1'b1, 8'h01, 1'b1);
      press <= 8'h00;
      settle();
      wr(`KPD_OFS_CTRL, 32'h17);
      look(1'b0, 8'h01, 1'b1);
      $display("test level mode done");
      // Random polarity and disabled-pin noise, one enabled pin at a time
      for (i = 0; i < 8; i++) begin
         rng = xs(rng);
         setup(8'h01 << i, rng[7:0], 1'b0);
         press <= (8'h01 << i) | (rng[15:8] & ~(8'h01 << i));
         settle();
         look(1'b1, 8'h01 << i, 1'b0);
         press <= 8'h00;
         settle();
      end
      $display("test random pins done");
      results();
   end
endmodule
